// file: verilog/cfg_space_pkg.sv
/*
 * Shared constants for the port configuration space decoder: port base
 * addresses, configuration offsets, storage slots, fixed field values and
 * write masks.
 * Assumes byte offsets within a port and dword-wide accesses with byte enables.
 */
package cfg_space_pkg;

   // ----------------------------------------------------------------------
   // Flat address layout
   // ----------------------------------------------------------------------
   localparam int          PORT_MAX       = 8;         // Ports the map has room for
   localparam int          SYS_ADDR_W     = 15;        // Flat system address width
   localparam int          OFFSET_W       = 12;        // Port-relative byte offset width
   localparam int          PORT_W         = 3;         // Port number width
   localparam int          SLOT_CNT       = 20;        // Storage words per port
   localparam logic [14:0] PORT0_BASE     = 15'h0000;  // Upstream port base
   localparam logic [14:0] PORT_BASE_STEP = 15'h1000;  // Step between port bases
   localparam logic [14:0] LAST_PORT_BASE = 15'h7000;  // Base of port 7

   // ----------------------------------------------------------------------
   // Configuration offsets (byte addresses inside one port)
   // ----------------------------------------------------------------------
   localparam logic [11:0] VENDOR_IDENT_OFF            = 12'h000;
   localparam logic [11:0] DEVICE_IDENT_OFF            = 12'h002;
   localparam logic [11:0] PCI_COMMAND_OFF             = 12'h004;
   localparam logic [11:0] PCI_STATUS_OFF              = 12'h006;
   localparam logic [11:0] REVISION_IDENT_OFF          = 12'h008;
   localparam logic [11:0] CLASS_CODE_OFF              = 12'h009;
   localparam logic [11:0] CACHE_LINE_SIZE_OFF         = 12'h00c;
   localparam logic [11:0] PRIMARY_LATENCY_TIMER_OFF   = 12'h00d;
   localparam logic [11:0] HEADER_TYPE_OFF             = 12'h00e;
   localparam logic [11:0] SELF_TEST_OFF               = 12'h00f;
   localparam logic [11:0] BASE_ADDR_ZERO_OFF          = 12'h010;
   localparam logic [11:0] BASE_ADDR_ONE_OFF           = 12'h014;
   localparam logic [11:0] PRIMARY_BUS_NUMBER_OFF      = 12'h018;
   localparam logic [11:0] SECONDARY_BUS_NUMBER_OFF    = 12'h019;
   localparam logic [11:0] SUBORDINATE_BUS_NUMBER_OFF  = 12'h01a;
   localparam logic [11:0] SECONDARY_LATENCY_TIMER_OFF = 12'h01b;
   localparam logic [11:0] IO_WINDOW_BASE_OFF          = 12'h01c;
   localparam logic [11:0] IO_WINDOW_LIMIT_OFF         = 12'h01d;
   localparam logic [11:0] SECONDARY_STATUS_OFF        = 12'h01e;
   localparam logic [11:0] MEM_WINDOW_BASE_OFF         = 12'h020;
   localparam logic [11:0] MEM_WINDOW_LIMIT_OFF        = 12'h022;
   localparam logic [11:0] PREF_MEM_WINDOW_BASE_OFF    = 12'h024;
   localparam logic [11:0] PREF_MEM_WINDOW_LIMIT_OFF   = 12'h026;
   localparam logic [11:0] PREF_MEM_BASE_UPPER_OFF     = 12'h028;
   localparam logic [11:0] PREF_MEM_LIMIT_UPPER_OFF    = 12'h02c;
   localparam logic [11:0] IO_WINDOW_BASE_UPPER_OFF    = 12'h030;
   localparam logic [11:0] IO_WINDOW_LIMIT_UPPER_OFF   = 12'h032;
   localparam logic [11:0] CAPABILITY_LIST_POINTER_OFF = 12'h034;
   localparam logic [11:0] EXPANSION_ROM_BASE_OFF      = 12'h038;
   localparam logic [11:0] INTR_BRIDGE_CTRL_OFF        = 12'h03c;
   localparam logic [11:0] EXPRESS_CAP_BLOCK_OFF       = 12'h040;
   localparam logic [11:0] GLOBAL_CONTROL_OFF          = 12'h400;  // Upstream only
   localparam logic [11:0] GLOBAL_STATUS_OFF           = 12'h404;  // Upstream only
   localparam logic [11:0] TEST_MODE_OFF               = 12'h408;  // Upstream only
   localparam logic [11:0] MSI_CAP_OFF                 = 12'h0d0;  // Downstream only
   localparam logic [11:0] MSI_ADDR_OFF                = 12'h0d4;  // Downstream only
   localparam logic [11:0] MSI_DATA_OFF                = 12'h0d8;  // Downstream only

   // ----------------------------------------------------------------------
   // Storage slots, fixed values and write masks
   // ----------------------------------------------------------------------
   localparam logic [4:0]  SLOT_HDR_LAST    = 5'h10;         // Header dwords 0x000..0x040
   localparam logic [4:0]  SLOT_EXTRA0      = 5'h11;         // Control / MSI header
   localparam logic [4:0]  SLOT_EXTRA1      = 5'h12;         // Status / MSI address
   localparam logic [4:0]  SLOT_EXTRA2      = 5'h13;         // Test mode / MSI data
   localparam logic [31:0] STORE_RESET      = 32'h0000_0000;
   localparam logic [7:0]  HEADER_TYPE_BRG  = 8'h01;         // Type 1 bridge header
   localparam logic [31:0] STATUS_CAP_LIST  = 32'h0010_0000; // Capability list present
   localparam logic [31:0] MSI_CAP_HEADER   = 32'h0000_0005; // MSI id, end of list
   localparam logic [31:0] MASK_ALL         = 32'hffff_ffff;
   localparam logic [31:0] MASK_LOW_HALF    = 32'h0000_ffff;
   localparam logic [31:0] MASK_BRIDGE_CTRL = 32'hffff_00ff; // Line and bridge ctl
   localparam logic [31:0] MASK_MSI_ENABLE  = 32'h0001_0000;
   localparam int          WR_BLOCK_BIT     = 0;             // Global control bit

endpackage : cfg_space_pkg

// file: verilog/port_config_space_decode.sv
/*
 * Register space of an eight-port switch: per-port configuration headers,
 * the flat system address used by the EEPROM loader and slave SMBus, and
 * the handling of undefined offsets.
 * Assumes both request ports are driven by logic on REF_CLK, so no input
 * synchroniser is needed; one request at a time per port.
 */
`timescale 1ns/10ps

// Summary of operation
// - Every register lives in one port's space
// - Flat address is port base plus offset
// - Port bases 0x0000 up, step 0x1000
// - EEPROM and SMBus use flat addresses
// - Global control, status, test upstream only
// - MSI capability downstream only
// - Undefined config reads return zero
// - Undefined SMBus reads also return zero
// - Undefined writes complete, change nothing
// - Class code three bytes at 0x009
// - Bus numbers at 0x018, 0x019, 0x01A
// - Capabilities pointer byte at 0x034
// - Express capability dword at 0x040
module port_config_space_decode #(
   parameter int          PORTS          = 8,              // Ports in the switch
   parameter logic [15:0] VENDOR_IDENT   = 16'h1234,       // Arbitrary value
   parameter logic [15:0] DEVICE_IDENT   = 16'h5678,       // Arbitrary value
   parameter logic [7:0]  REVISION_IDENT = 8'h01,          // Arbitrary value
   parameter logic [23:0] CLASS_CODE     = 24'h060400,     // Bridge class
   parameter logic [7:0]  CAP_POINTER    = 8'h40,          // First capability
   parameter logic [31:0] EXPRESS_CAP    = 32'h0052_0010   // Express cap header
) (
   input  wire logic                                  REF_CLK,
   input  wire logic                                  RESETN,
   input  wire logic                                  CFG_REQ,
   input  wire logic                                  CFG_WR,
   input  wire logic [cfg_space_pkg::PORT_W-1:0]      CFG_PORT,
   input  wire logic [cfg_space_pkg::OFFSET_W-1:0]    CFG_OFFSET,
   input  wire logic [3:0]                            CFG_BE,
   input  wire logic [31:0]                           CFG_WDATA,
   output      logic                                  CFG_ACK,
   output      logic [31:0]                           CFG_RDATA,
   input  wire logic                                  SYS_REQ,
   input  wire logic                                  SYS_WR,
   input  wire logic [cfg_space_pkg::SYS_ADDR_W-1:0]  SYS_ADDR,
   input  wire logic [3:0]                            SYS_BE,
   input  wire logic [31:0]                           SYS_WDATA,
   output      logic                                  SYS_READY,
   output      logic                                  SYS_ACK,
   output      logic [31:0]                           SYS_RDATA,
   output      logic [7:0]                            UP_PRIMARY_BUS,
   output      logic [7:0]                            UP_SECONDARY_BUS,
   output      logic [7:0]                            UP_SUBORDINATE_BUS
);
   import cfg_space_pkg::*;

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   // The flat map only has room for eight 4 KB port windows
   if (PORTS < 2 || PORTS > PORT_MAX) begin : g_bad_ports
      $error("PORTS must lie between 2 and 8");
   end

   // -------------------------------------------------------------------------
   // Decode functions
   // -------------------------------------------------------------------------
   // Base of a port window in the flat map
   function automatic logic [14:0] port_base(input logic [2:0] port);
      port_base = PORT0_BASE + 15'(port) * PORT_BASE_STEP;
   endfunction : port_base

   // Maps port and dword offset to {valid, slot}
   function automatic logic [5:0] slot_of(input logic [2:0] port, input logic [9:0] dw);
      logic [5:0] r;
      r = 6'h00;
      if (32'(port) >= PORTS) begin
         r = 6'h00;                                           // No such port
      end else if (dw <= 10'(SLOT_HDR_LAST)) begin
         r = {1'b1, dw[4:0]};                                 // Shared header
      end else if (port == 3'd0) begin
         // Global registers exist in the upstream window alone
         if (dw == GLOBAL_CONTROL_OFF[11:2]) r = {1'b1, SLOT_EXTRA0};
         if (dw == GLOBAL_STATUS_OFF[11:2])  r = {1'b1, SLOT_EXTRA1};
         if (dw == TEST_MODE_OFF[11:2])      r = {1'b1, SLOT_EXTRA2};
      end else begin
         // Hot-plug MSI structure in downstream windows alone
         if (dw == MSI_CAP_OFF[11:2])  r = {1'b1, SLOT_EXTRA0};
         if (dw == MSI_ADDR_OFF[11:2]) r = {1'b1, SLOT_EXTRA1};
         if (dw == MSI_DATA_OFF[11:2]) r = {1'b1, SLOT_EXTRA2};
      end
      slot_of = r;
   endfunction : slot_of

   // Bits software may change in a slot
   function automatic logic [31:0] wmask(input logic upstream, input logic [4:0] slot);
      logic [31:0] m;
      m = MASK_ALL;
      unique case (slot)
         5'h00, 5'h02, 5'h0d, 5'h10: m = '0;                  // Identity, pointers
         5'h01, 5'h03, 5'h07:        m = MASK_LOW_HALF;       // Status, header type halves read-only
         5'h0f:                      m = MASK_BRIDGE_CTRL;    // Interrupt pin read-only
         SLOT_EXTRA0:                m = upstream ? MASK_ALL : MASK_MSI_ENABLE;
         SLOT_EXTRA1:                m = upstream ? '0 : MASK_ALL;
         default:                    m = MASK_ALL;            // Plain read-write words
      endcase
      wmask = m;
   endfunction : wmask

   // Read-only content of a slot
   function automatic logic [31:0] fixed_val(input logic upstream, input logic [4:0] slot);
      logic [31:0] v;
      v = '0;
      unique case (slot)
         5'h00: v = {DEVICE_IDENT, VENDOR_IDENT};
         5'h01: v = STATUS_CAP_LIST;
         // Revision byte then three class bytes
         5'h02: v = (32'(REVISION_IDENT) << (8 * REVISION_IDENT_OFF[1:0]))
                  | (32'(CLASS_CODE) << (8 * CLASS_CODE_OFF[1:0]));
         5'h03: v = 32'(HEADER_TYPE_BRG) << (8 * HEADER_TYPE_OFF[1:0]);
         // Pointer byte opens the capability list
         5'h0d: v = 32'(CAP_POINTER) << (8 * CAPABILITY_LIST_POINTER_OFF[1:0]);
         5'h10: v = EXPRESS_CAP;
         SLOT_EXTRA0: v = upstream ? '0 : MSI_CAP_HEADER;
         default: v = '0;
      endcase
      fixed_val = v;
   endfunction : fixed_val

   // Merge only the enabled byte lanes into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] m);
      logic [31:0] bm;
      bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & m;
      merge = (old & ~bm) | (wd & bm);
   endfunction : merge

   // -------------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------------
   logic [31:0] store_q [PORTS][SLOT_CNT];   // Writable bits of every port
   logic        cfg_ack_q;                   // Config answer strobe
   logic        sys_ack_q;                   // Flat path answer strobe
   logic [31:0] cfg_rdata_q;                 // Config read data
   logic [31:0] sys_rdata_q;                 // Flat path read data

   // -------------------------------------------------------------------------
   // Request selection and flat address
   // -------------------------------------------------------------------------
   // Configuration requests win; the flat path waits while CFG_REQ is high
   wire         cfg_take   = CFG_REQ;
   wire         sys_take   = SYS_REQ & ~CFG_REQ;
   wire         any_take   = cfg_take | sys_take;
   wire         take_wr    = cfg_take ? CFG_WR : SYS_WR;
   wire  [3:0]  take_be    = cfg_take ? CFG_BE : SYS_BE;
   wire  [31:0] take_wdata = cfg_take ? CFG_WDATA : SYS_WDATA;

   // Config accesses are folded into the same flat address
   wire  [14:0] cfg_flat   = port_base(CFG_PORT) + {3'b000, CFG_OFFSET};
   // Loader and SMBus already speak flat addresses
   wire  [14:0] flat_addr  = cfg_take ? cfg_flat : SYS_ADDR;

   // One decode serves both paths, so each register has one home
   wire  [2:0]  dec_port   = flat_addr[14:12];
   wire  [9:0]  dec_dw     = flat_addr[11:2];
   wire  [5:0]  dec_slot   = slot_of(dec_port, dec_dw);
   wire         dec_valid  = dec_slot[5];
   wire  [4:0]  slot       = dec_slot[4:0];
   wire         upstream   = (dec_port == 3'd0);
   wire  [31:0] slot_mask  = wmask(upstream, slot);

   // -------------------------------------------------------------------------
   // Global control effect and status
   // -------------------------------------------------------------------------
   // Control bit lets firmware fence off the flat path from writes
   wire         sys_wr_block = store_q[0][SLOT_EXTRA0][WR_BLOCK_BIT];
   wire  [31:0] global_sts   = {16'h0000, 8'(PORTS), 7'h00, sys_wr_block};

   // Undefined offsets keep every stored bit
   wire         store_we   = any_take & take_wr & dec_valid & ~(sys_take & sys_wr_block);

   // Read word: stored bits under the mask, fixed bits elsewhere
   wire  [31:0] stored_word = store_q[dec_port][slot] & slot_mask;
   wire  [31:0] live_word   = (upstream && slot == SLOT_EXTRA1) ? global_sts
                                                                : stored_word | fixed_val(upstream, slot);
   // Zero for undefined config reads, the flat path also gets zero
   wire  [31:0] read_word   = dec_valid ? live_word : '0;

   // -------------------------------------------------------------------------
   // Storage update
   // -------------------------------------------------------------------------
   // Writes land at the edge that takes the request
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         for (int p = 0; p < PORTS; p++) begin
            for (int s = 0; s < SLOT_CNT; s++) begin
               store_q[p][s] <= STORE_RESET;
            end
         end
      end else if (store_we) begin
         store_q[dec_port][slot] <= merge(store_q[dec_port][slot], take_wdata, take_be, slot_mask);
      end
   end

   // -------------------------------------------------------------------------
   // Answers
   // -------------------------------------------------------------------------
   // Each taken request is answered one cycle later, writes included
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_ack_q   <= 1'b0;
         sys_ack_q   <= 1'b0;
         cfg_rdata_q <= '0;
         sys_rdata_q <= '0;
      end else begin
         cfg_ack_q <= cfg_take;
         sys_ack_q <= sys_take;
         // Read data holds until the next read of the same path
         if (cfg_take && !CFG_WR) begin
            cfg_rdata_q <= read_word;
         end
         if (sys_take && !SYS_WR) begin
            sys_rdata_q <= read_word;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign CFG_ACK   = cfg_ack_q;
   assign CFG_RDATA = cfg_rdata_q;
   assign SYS_ACK   = sys_ack_q;
   assign SYS_RDATA = sys_rdata_q;
   // Flat path stalls while a config request is present
   assign SYS_READY = ~CFG_REQ;

   // Upstream bus numbers by their byte lanes
   assign UP_PRIMARY_BUS     = store_q[0][PRIMARY_BUS_NUMBER_OFF[6:2]][8*PRIMARY_BUS_NUMBER_OFF[1:0] +: 8];
   assign UP_SECONDARY_BUS   = store_q[0][SECONDARY_BUS_NUMBER_OFF[6:2]][8*SECONDARY_BUS_NUMBER_OFF[1:0] +: 8];
   assign UP_SUBORDINATE_BUS = store_q[0][SUBORDINATE_BUS_NUMBER_OFF[6:2]][8*SUBORDINATE_BUS_NUMBER_OFF[1:0] +: 8];

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   // Config read of the upstream window at one dword
   sequence s_up_read(logic [9:0] dw);
      CFG_REQ && !CFG_WR && CFG_PORT == 3'd0 && CFG_OFFSET[11:2] == dw;
   endsequence
   // Config read of a downstream window at one dword
   sequence s_down_read(logic [9:0] dw);
      CFG_REQ && !CFG_WR && CFG_PORT != 3'd0 && CFG_OFFSET[11:2] == dw;
   endsequence

   a_cfg_ack_timing: assert property (CFG_REQ |=> CFG_ACK ##1 (CFG_ACK == $past(CFG_REQ)))
      else $error("Config request not answered on the next cycle");
   a_sys_stall_order: assert property (SYS_REQ && CFG_REQ |=> !SYS_ACK && CFG_ACK)
      else $error("Flat request answered while a config request held it off");
   a_flat_port_base: assert property (SYS_REQ && !CFG_REQ && !SYS_WR && SYS_ADDR == LAST_PORT_BASE
                                      && PORTS == 8 |=> SYS_RDATA == {DEVICE_IDENT, VENDOR_IDENT})
      else $error("Flat address of port 7 identity is wrong");
   a_flat_matches_cfg: assert property (CFG_REQ |-> cfg_flat[14:12] == CFG_PORT
                                        && cfg_flat[11:0] == CFG_OFFSET)
      else $error("Config access mapped to the wrong flat address");
   a_undef_read_zero: assert property (CFG_REQ && !CFG_WR && !dec_valid |=> CFG_ACK && CFG_RDATA == 32'h0)
      else $error("Undefined config read returned nonzero data");
   a_undef_write_none: assert property (any_take && take_wr && !dec_valid |-> !store_we)
      else $error("Write to an undefined offset changed storage");
   a_global_up_only: assert property (s_down_read(GLOBAL_CONTROL_OFF[11:2]) |=> CFG_RDATA == 32'h0)
      else $error("Global control visible in a downstream port");
   a_msi_down_only: assert property (s_up_read(MSI_CAP_OFF[11:2]) |=> CFG_RDATA == 32'h0)
      else $error("MSI structure visible in the upstream port");
   a_msi_down_present: assert property (s_down_read(MSI_CAP_OFF[11:2]) && 32'(CFG_PORT) < PORTS
                                        |=> CFG_RDATA[15:0] == MSI_CAP_HEADER[15:0])
      else $error("MSI header missing in a downstream port");
   a_class_code_pos: assert property (s_up_read(CLASS_CODE_OFF[11:2])
                                      |=> CFG_RDATA == {CLASS_CODE, REVISION_IDENT})
      else $error("Revision or class code in the wrong bytes");
   a_bus_num_lanes: assert property (CFG_REQ && CFG_WR && CFG_PORT == 3'd0 && CFG_BE == 4'b0111
                                     && CFG_OFFSET[11:2] == PRIMARY_BUS_NUMBER_OFF[11:2]
                                     |=> UP_PRIMARY_BUS == $past(CFG_WDATA[7:0])
                                     && UP_SECONDARY_BUS == $past(CFG_WDATA[15:8])
                                     && UP_SUBORDINATE_BUS == $past(CFG_WDATA[23:16]))
      else $error("Bus number bytes not at consecutive offsets");
   a_cap_pointer: assert property (s_up_read(CAPABILITY_LIST_POINTER_OFF[11:2]) |=> CFG_RDATA[7:0] == CAP_POINTER)
      else $error("Capabilities pointer not at its offset");
   a_express_cap: assert property (s_up_read(EXPRESS_CAP_BLOCK_OFF[11:2]) |=> CFG_RDATA == EXPRESS_CAP)
      else $error("Express capability not at its offset");
   a_partial_write: assert property (CFG_REQ && CFG_WR && CFG_PORT == 3'd0 && !CFG_BE[3]
                                     && CFG_OFFSET[11:2] == PRIMARY_BUS_NUMBER_OFF[11:2]
                                     |=> store_q[0][6][31:24] == $past(store_q[0][6][31:24]))
      else $error("Disabled byte lane was written");

endmodule : port_config_space_decode

// file: verification/flat_master.sv
/* Flat-address master model standing for the EEPROM loader or SMBus master.
   Assumes REF_CLK comes from the bench and SYS_READY from the decoder. */
`timescale 1ns/10ps
module flat_master (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_READY,
   input  wire logic        SYS_ACK,
   input  wire logic [31:0] SYS_RDATA,
   output      logic        SYS_REQ,
   output      logic        SYS_WR,
   output      logic [14:0] SYS_ADDR,
   output      logic [3:0]  SYS_BE,
   output      logic [31:0] SYS_WDATA
);
   initial {SYS_REQ, SYS_WR, SYS_ADDR, SYS_BE, SYS_WDATA} = '0;
   // Hold the request until taken; answer is sampled just after the taking edge
   task automatic xfer(input logic w, input logic [14:0] a, input logic [3:0] b, input logic [31:0] d,
                       output logic [31:0] q, output logic k);
      {SYS_REQ, SYS_WR, SYS_ADDR, SYS_BE, SYS_WDATA} = {1'b1, w, a, b, d};
      do @(posedge REF_CLK); while (!SYS_READY);
      #1 q = SYS_RDATA;
      k = SYS_ACK;
      // Released address and data lines show the inverse, so a stale value never passes
      {SYS_REQ, SYS_ADDR, SYS_WDATA} = {1'b0, ~a, ~d};
   endtask : xfer
endmodule : flat_master

// file: verification/tb_top.sv
/* Self-checking bench for the port configuration space decoder.
   Assumes the flat path is driven only through the flat_master model. */
`timescale 1ns/10ps
module tb_top;
   import cfg_space_pkg::*;
   logic REF_CLK = 0, RESETN = 0, CFG_REQ = 0, CFG_WR = 0, CFG_ACK, SYS_REQ, SYS_WR, SYS_READY, SYS_ACK, k;
   logic [2:0]  CFG_PORT = 0;
   logic [11:0] CFG_OFFSET = 0;
   logic [3:0]  CFG_BE = 0, SYS_BE;
   logic [14:0] SYS_ADDR;
   logic [31:0] CFG_WDATA = 0, CFG_RDATA, SYS_WDATA, SYS_RDATA, rnd = 43, q, v;
   logic [7:0]  UP_PRIMARY_BUS, UP_SECONDARY_BUS, UP_SUBORDINATE_BUS;
   int          err_total = 0, n_checks = 0;
   port_config_space_decode u_port_config_space_decode (.*);
   flat_master u_flat_master (.*);
   initial forever #20 REF_CLK = ~REF_CLK;
   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rnd
   // Byte-lane merge of a write into the previous word
   function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] b);
      for (int i = 0; i < 4; i++) if (b[i]) o[8*i+:8] = n[8*i+:8];
      return o;
   endfunction : merge
   task automatic chk(input string n, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic cfg(input logic w, input int p, input logic [11:0] o, input logic [3:0] b, input logic [31:0] d);
      {CFG_REQ, CFG_WR, CFG_PORT, CFG_OFFSET, CFG_BE, CFG_WDATA} = {1'b1, w, 3'(p), o, b, d};
      @(posedge REF_CLK) #1;
      q = CFG_RDATA;
      k = CFG_ACK;
      CFG_REQ = 0;
      chk("cfg_ack", {31'h0, k}, 32'h1);
      @(posedge REF_CLK) #1;
   endtask : cfg
   // Flat address is the port base plus the offset
   task automatic sys(input logic w, input int p, input logic [11:0] o, input logic [3:0] b, input logic [31:0] d);
      u_flat_master.xfer(w, PORT0_BASE + 15'(p) * PORT_BASE_STEP + {3'h0, o}, b, d, q, k);
      chk("sys_ack", {31'h0, k}, 32'h1);
      @(posedge REF_CLK) #1;
   endtask : sys
   initial begin
      repeat (16) @(posedge REF_CLK);
      #1 RESETN = 1;
      chk("up_bus_rst", {8'h0, UP_PRIMARY_BUS, UP_SECONDARY_BUS, UP_SUBORDINATE_BUS}, 0);
      for (int p = 0; p < PORT_MAX; p++) begin
         rnd = next_rnd(rnd);
         sys(0, p, VENDOR_IDENT_OFF, 4'hf, rnd);
         chk("ident", q, 32'h5678_1234);
         cfg(0, p, REVISION_IDENT_OFF, 4'hf, rnd);
         chk("class_rev", q, 32'h0604_0001);
         sys(1, p, PRIMARY_BUS_NUMBER_OFF, rnd[3:0], rnd);
         cfg(0, p, PRIMARY_BUS_NUMBER_OFF, 4'h0, 0);
         chk("bus_flat", q, merge(0, rnd, rnd[3:0]));
         cfg(1, p, PRIMARY_BUS_NUMBER_OFF, 4'h7, ~rnd);
         v = merge(merge(0, rnd, rnd[3:0]), ~rnd, 4'h7);
         cfg(0, p, PRIMARY_BUS_NUMBER_OFF, 4'h0, 0);
         chk("bus_merge", q, v);
         if (p == 0) chk("up_bus", {8'h0, UP_PRIMARY_BUS, UP_SECONDARY_BUS, UP_SUBORDINATE_BUS},
                         {8'h0, v[7:0], v[15:8], v[23:16]});
         cfg(1, p, 12'h044, 4'hf, rnd);
         sys(1, p, 12'h044, 4'hf, ~rnd);
         cfg(0, p, 12'h044, 4'hf, 0);
         chk("undef", q, 0);
         cfg(0, p, GLOBAL_STATUS_OFF, 4'hf, 0);
         chk("glob_stat", q, (p == 0) ? 32'h0000_0800 : 0);
         cfg(0, p, MSI_CAP_OFF, 4'hf, 0);
         chk("msi_cap", q, (p == 0) ? 0 : MSI_CAP_HEADER);
      end
      cfg(0, 0, CAPABILITY_LIST_POINTER_OFF, 4'hf, 0);
      chk("cap_ptr", q, 32'h0000_0040);
      cfg(0, 0, EXPRESS_CAP_BLOCK_OFF, 4'hf, 0);
      chk("exp_cap", q, 32'h0052_0010);
      // Config and flat requests meet: the flat one must wait a cycle
      fork
         cfg(0, 0, REVISION_IDENT_OFF, 4'hf, 0);
         begin
            #0 chk("sys_ready", {31'h0, SYS_READY}, 0);
            u_flat_master.xfer(0, LAST_PORT_BASE, 4'hf, 0, v, k);
         end
      join
      chk("stall_cfg", q, 32'h0604_0001);
      chk("stall_ident", v, 32'h5678_1234);
      chk("stall_ack", {31'h0, k}, 32'h1);
      @(posedge REF_CLK) #1;
      // Fence the flat path against writes, then try one
      cfg(1, 0, GLOBAL_CONTROL_OFF, 4'h1, 32'h1);
      sys(1, 0, TEST_MODE_OFF, 4'hf, 32'hffff_ffff);
      cfg(0, 0, TEST_MODE_OFF, 4'hf, 0);
      chk("wr_block", q, 0);
      cfg(0, 0, GLOBAL_STATUS_OFF, 4'hf, 0);
      chk("glob_fence", q, 32'h0000_0801);
      wrap_up;
   end
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      #200_000;
      err_total++;
      wrap_up;
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
endmodule : tb_top
